// ===== include/ssp_pkg.sv
package ssp_pkg;

	// Setting pin band edges, in millivolts on the pin
	localparam logic [11:0] BAND1_MV = 12'd249;
	localparam logic [11:0] BAND2_MV = 12'd787;
	localparam logic [11:0] BAND3_MV = 12'd1348;
	localparam logic [11:0] BAND4_MV = 12'd1921;
	localparam logic [11:0] BAND5_MV = 12'd2779;

	// Requested bus voltage per band, in millivolts
	localparam logic [15:0] VREQ0_MV = 16'd5000;
	localparam logic [15:0] VREQ1_MV = 16'd9000;
	localparam logic [15:0] VREQ2_MV = 16'd12000;
	localparam logic [15:0] VREQ3_MV = 16'd15000;
	localparam logic [15:0] VREQ4_MV = 16'd19000;
	localparam logic [15:0] VREQ5_MV = 16'd20000;

	// Legacy acceptance window when both voltage settings are 5 V
	localparam logic [15:0] LEG5_LO_MV = 16'd4750;
	localparam logic [15:0] LEG5_HI_MV = 16'd5500;

	// Current steps, in milliamps
	localparam logic [15:0] COARSE_STEP_MA = 16'd1000;
	localparam logic [15:0] FINE1_MA       = 16'd250;
	localparam logic [15:0] FINE2_MA       = 16'd500;
	localparam logic [15:0] FINE3_MA       = 16'd750;
	localparam logic [15:0] FINE4_MA       = 16'd900;

	// Register offsets
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_STATUS   = 4'h4;
	localparam logic [3:0] REG_SETTINGS = 4'h8;
	localparam logic [3:0] REG_REQUEST  = 4'hc;

	// Control register fields and reset value
	localparam int CTRL_FB_DIS  = 0;
	localparam int CTRL_LEG_DIS = 1;
	localparam int CTRL_OTP_EN  = 2;
	localparam int CTRL_HOST_EN = 3;
	localparam int CTRL_HOST_ON = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	typedef enum logic [5:0] {
		ST_SAMPLE   = 6'h01,
		ST_DETECT   = 6'h02,
		ST_EVAL     = 6'h04,
		ST_CONTRACT = 6'h08,
		ST_FALLBACK = 6'h10,
		ST_RECOVER  = 6'h20
	} ssp_state_e;

	typedef enum logic [2:0] {
		PR_NONE  = 3'h0,
		PR_PD    = 3'h1,
		PR_BC12  = 3'h2,
		PR_FC0   = 3'h3,
		PR_FC1   = 3'h4,
		PR_FC2   = 3'h5,
		PR_TYPEC = 3'h6
	} ssp_proto_e;

	typedef struct packed {
		logic       done;
		logic       pd;
		logic       bc12;
		logic [2:0] fc;
	} ssp_detect_s;

	typedef struct packed {
		logic        valid;
		logic        contract;
		logic [15:0] mv;
		logic [15:0] ma;
	} ssp_offer_s;

	typedef struct packed {
		logic ov;
		logic uv;
		logic oc;
		logic hot;
		logic conn_ov;
	} ssp_guard_s;

endpackage

// ===== rtl/ssp_sink_policy.sv
// Operation
// RQ1: Decode each voltage setting pin level into 5, 9, 12, 15, 19 or 20 V.
// RQ2: Decode the coarse current pin into 0 to 5 A using the same bands.
// RQ3: Decode the fine current pin into +0/250/500/750/900 mA added to coarse.
// RQ4: If minimum exceeds maximum, the maximum setting bounds both window edges.
// RQ5: Fault high on no PD contract with min not 5 V, no voltage fit, low current.
// RQ6: Fault high on bus out of limits, overcurrent, or overtemperature when enabled.
// RQ7: Fault holds its level during renegotiation, updates once the outcome is known.
// RQ8: Fallback gate on when the contract falls back to 5 V on mismatch.
// RQ9: Fallback gate stays off when 5 V is already an accepted supply.
// RQ10: Fallback gate stays off while the connector 5 V input is overvoltage.
// RQ11: A configuration bit disables the fallback gate entirely.
// RQ12: Main gate on when the adapter matches the voltage window and current.
// RQ13: Main gate off at once on bus overvoltage or undervoltage.
// RQ14: Host may turn the main gate on or off regardless of the policy.
// RQ15: Protocol order is PD, BC1.2, three fast-charge schemes, then Type-C only.
// RQ16: PD and BC1.2 detection run together; PD wins when present.
// RQ17: The legacy select strap enables all legacy schemes or BC1.2 only.
// RQ18: Pull-up on the select strap means BC1.2 only; floating means all.
// RQ19: Legacy uses the same settings; 5 V settings accept 4.75 V to 5.5 V.
// RQ20: Legacy adapter short of the need gives a 5 V contract and fallback gate.
// RQ21: A configuration bit disables all legacy negotiation.
// RQ22: On a fault, remove output power and attempt a protocol reset.
// RQ23: Setting pins are sampled after reset and held stable.
// RQ24: Main and fallback gates are never on together.
module ssp_sink_policy
	import ssp_pkg::*;
(
	// Clock and reset
	input  wire  logic        clk_i,
	input  wire  logic        reset_n_i,
	// Setting pin levels, millivolts, and the legacy select strap
	input  wire  logic [11:0] min_voltage_setting_i,
	input  wire  logic [11:0] max_voltage_setting_i,
	input  wire  logic [11:0] coarse_current_setting_i,
	input  wire  logic [11:0] fine_current_setting_i,
	input  wire  logic        legacy_select_pullup_i,
	// Adapter detection and offers
	input  wire  ssp_detect_s detect_i,
	input  wire  ssp_offer_s  offer_i,
	input  wire  logic        renegotiating_i,
	// Protection monitors
	input  wire  ssp_guard_s  guard_i,
	// Register port
	input  wire  logic [3:0]  reg_addr_i,
	input  wire  logic [31:0] reg_wdata_i,
	input  wire  logic        reg_wr_i,
	input  wire  logic        reg_rd_i,
	output logic [31:0]       reg_rdata_o,
	// Negotiation control
	output ssp_proto_e        proto_o,
	output logic              negotiate_o,
	output logic [15:0]       req_min_mv_o,
	output logic [15:0]       req_max_mv_o,
	output logic [15:0]       req_ma_o,
	output logic              protocol_reset_o,
	// Power path and indication
	output logic              fault_o,
	output logic              main_power_gate_enable_o,
	output logic              fallback_power_gate_enable_o
);

	function automatic logic [2:0] band_code(input logic [11:0] mv);
		logic [2:0] code;
		code = 3'd0;
		if (mv >= BAND1_MV) code = 3'd1;
		if (mv >= BAND2_MV) code = 3'd2;
		if (mv >= BAND3_MV) code = 3'd3;
		if (mv >= BAND4_MV) code = 3'd4;
		if (mv >= BAND5_MV) code = 3'd5;
		return code;
	endfunction

	function automatic logic [15:0] code_mv(input logic [2:0] code);
		logic [15:0] mv;
		mv = VREQ0_MV;
		unique case (code)
			3'd1:    mv = VREQ1_MV;
			3'd2:    mv = VREQ2_MV;
			3'd3:    mv = VREQ3_MV;
			3'd4:    mv = VREQ4_MV;
			3'd5:    mv = VREQ5_MV;
			default: mv = VREQ0_MV;
		endcase
		return mv;
	endfunction

	// Decoded settings, frozen after the first edge past reset release
	logic       sampled_r;
	logic [2:0] vmin_code_r;
	logic [2:0] vmax_code_r;
	logic [2:0] coarse_code_r;
	logic [2:0] fine_code_r;
	logic       bc12_only_r;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sampled_r     <= 1'b0;
			vmin_code_r   <= 3'd0;
			vmax_code_r   <= 3'd0;
			coarse_code_r <= 3'd0;
			fine_code_r   <= 3'd0;
			bc12_only_r   <= 1'b0;
		end else if (!sampled_r) begin
			sampled_r     <= 1'b1; // RQ23
			vmin_code_r   <= band_code(min_voltage_setting_i); // RQ1
			vmax_code_r   <= band_code(max_voltage_setting_i); // RQ1
			coarse_code_r <= band_code(coarse_current_setting_i); // RQ2
			// Fine pin saturates at its fifth band
			fine_code_r   <= (band_code(fine_current_setting_i) > 3'd4) ? 3'd4 :
				band_code(fine_current_setting_i); // RQ3
			bc12_only_r   <= legacy_select_pullup_i; // RQ18
		end
	end

	// Voltage window and current requirement
	logic [2:0]  lo_code;
	logic [15:0] win_lo_mv;
	logic [15:0] win_hi_mv;
	logic [15:0] fine_ma;
	logic [15:0] need_ma;
	logic        both_5v;
	logic        accept_5v;

	always_comb begin
		lo_code = (vmin_code_r > vmax_code_r) ? vmax_code_r : vmin_code_r; // RQ4
		win_lo_mv = code_mv(lo_code);
		win_hi_mv = code_mv(vmax_code_r);
		unique case (fine_code_r)
			3'd1:    fine_ma = FINE1_MA;
			3'd2:    fine_ma = FINE2_MA;
			3'd3:    fine_ma = FINE3_MA;
			3'd4:    fine_ma = FINE4_MA;
			default: fine_ma = 16'h0000;
		endcase
		need_ma = 16'(COARSE_STEP_MA * 16'(coarse_code_r)) + fine_ma; // RQ3
	end

	assign both_5v   = (lo_code == 3'd0) && (vmax_code_r == 3'd0);
	assign accept_5v = (lo_code == 3'd0);

	// Control register
	logic [4:0] ctrl_r;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_r <= CTRL_RESET;
		end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
			ctrl_r <= reg_wdata_i[4:0];
		end
	end

	logic leg_en;
	logic fc_en;
	assign leg_en = !ctrl_r[CTRL_LEG_DIS]; // RQ21
	assign fc_en  = leg_en && !bc12_only_r; // RQ17

	// Policy state, declared ahead of the offer logic that reads the chosen protocol
	ssp_state_e state_r;
	ssp_state_e state_nxt;
	ssp_proto_e proto_r;
	ssp_proto_e proto_nxt;
	logic       nego_fault_r;
	logic       nego_fault_nxt;

	// Offer evaluation against the window
	logic is_legacy;
	logic volt_fit;
	logic curr_fit;
	logic pd_no_contract;

	always_comb begin
		is_legacy = (proto_r != PR_PD) && (proto_r != PR_TYPEC);
		if (is_legacy && both_5v) begin
			volt_fit = (offer_i.mv >= LEG5_LO_MV) && (offer_i.mv <= LEG5_HI_MV); // RQ19
		end else begin
			volt_fit = (offer_i.mv >= win_lo_mv) && (offer_i.mv <= win_hi_mv); // RQ19
		end
		curr_fit = (offer_i.ma >= need_ma);
		pd_no_contract = (proto_r == PR_PD) && !offer_i.contract;
	end

	logic guard_trip;
	logic bus_bad;
	assign bus_bad    = guard_i.ov || guard_i.uv;
	assign guard_trip = bus_bad || guard_i.oc || (ctrl_r[CTRL_OTP_EN] && guard_i.hot); // RQ6

	// Policy state machine
	always_comb begin
		state_nxt      = state_r;
		proto_nxt      = proto_r;
		nego_fault_nxt = nego_fault_r;
		unique case (state_r)
			ST_SAMPLE: begin
				if (sampled_r) state_nxt = ST_DETECT;
			end
			ST_DETECT: begin
				if (detect_i.done) begin
					state_nxt = ST_EVAL;
					// PD is checked before BC1.2 although both are detected together
					if (detect_i.pd)                    proto_nxt = PR_PD; // RQ16
					else if (leg_en && detect_i.bc12)   proto_nxt = PR_BC12; // RQ15
					else if (fc_en && detect_i.fc[0])   proto_nxt = PR_FC0; // RQ15
					else if (fc_en && detect_i.fc[1])   proto_nxt = PR_FC1; // RQ15
					else if (fc_en && detect_i.fc[2])   proto_nxt = PR_FC2; // RQ15
					else                                proto_nxt = PR_TYPEC; // RQ15
				end
			end
			ST_EVAL: begin
				if (offer_i.valid) begin
					if (pd_no_contract) begin
						nego_fault_nxt = !accept_5v; // RQ5
						state_nxt      = ST_FALLBACK;
					end else if (volt_fit && curr_fit) begin
						nego_fault_nxt = 1'b0;
						state_nxt      = ST_CONTRACT; // RQ12
					end else begin
						nego_fault_nxt = 1'b1; // RQ5
						state_nxt      = ST_FALLBACK; // RQ20
					end
				end
			end
			ST_CONTRACT, ST_FALLBACK: begin
				if (guard_trip) begin
					state_nxt = ST_RECOVER; // RQ22
				end else if (renegotiating_i) begin
					state_nxt = ST_EVAL;
				end
			end
			ST_RECOVER: begin
				state_nxt = ST_DETECT; // RQ22
				proto_nxt = PR_NONE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r      <= ST_SAMPLE;
			proto_r      <= PR_NONE;
			nego_fault_r <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			proto_r      <= proto_nxt;
			nego_fault_r <= nego_fault_nxt;
		end
	end

	// Fault indication; frozen while a contract is being renegotiated
	logic fault_r;
	logic fault_nxt;
	assign fault_nxt = nego_fault_r || guard_trip; // RQ5 RQ6

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fault_r <= 1'b0;
		end else if (!renegotiating_i && state_r != ST_EVAL) begin
			fault_r <= fault_nxt; // RQ7
		end
	end

	// Protocol reset request toward the adapter link
	logic proto_rst_r;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			proto_rst_r <= 1'b0;
		end else begin
			proto_rst_r <= (state_nxt == ST_RECOVER) && (state_r != ST_RECOVER); // RQ22
		end
	end

	// Gate drives
	logic auto_main;
	logic main_on;
	logic fb_on;

	always_comb begin
		auto_main = (state_r == ST_CONTRACT); // RQ12
		if (ctrl_r[CTRL_HOST_EN]) begin
			main_on = ctrl_r[CTRL_HOST_ON]; // RQ14
		end else begin
			main_on = auto_main;
		end
		// Combinational cut so a bus excursion opens the gate without a cycle of delay
		if (bus_bad) main_on = 1'b0; // RQ13
		fb_on = (state_r == ST_FALLBACK) // RQ8
			&& !accept_5v // RQ9
			&& !guard_i.conn_ov // RQ10
			&& !ctrl_r[CTRL_FB_DIS] // RQ11
			&& !main_on; // RQ24
	end

	// Register read port
	logic [31:0] rdata_r;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_CTRL:     rdata_r <= {27'h000_0000, ctrl_r};
				REG_STATUS:   rdata_r <= {16'h0000, 2'b00, state_r, proto_r, fault_r,
					fb_on, main_on, nego_fault_r, bc12_only_r};
				REG_SETTINGS: rdata_r <= {20'h0_0000, fine_code_r, coarse_code_r,
					vmax_code_r, vmin_code_r};
				REG_REQUEST:  rdata_r <= {need_ma, win_lo_mv};
				default:      rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign reg_rdata_o                  = rdata_r;
	assign proto_o                      = proto_r;
	assign negotiate_o                  = (state_r == ST_EVAL);
	assign req_min_mv_o                 = win_lo_mv;
	assign req_max_mv_o                 = win_hi_mv;
	assign req_ma_o                     = need_ma;
	assign protocol_reset_o             = proto_rst_r;
	assign fault_o                      = fault_r;
	assign main_power_gate_enable_o     = main_on;
	assign fallback_power_gate_enable_o = fb_on;

endmodule // ssp_sink_policy

// ===== sim/ssp_adapter_model.sv
module ssp_adapter_model
	import ssp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// Sink side
	input  wire logic        negotiate_i,
	output ssp_detect_s      detect_o,
	output ssp_offer_s       offer_o,
	// Capabilities chosen by the bench
	input  wire logic        pd_i,
	input  wire logic        bc12_i,
	input  wire logic [2:0]  fc_i,
	input  wire logic        contract_i,
	input  wire logic [15:0] mv_i,
	input  wire logic [15:0] ma_i,
	input  wire logic [3:0]  dly_i
);
	logic       done_r;
	logic       valid_r;
	logic [3:0] dcnt_r;
	logic [3:0] ocnt_r;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dcnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			dcnt_r <= dcnt_r + 4'h1;
			done_r <= done_r | (dcnt_r == dly_i);
		end
	end

	// A larger dly_i makes a slow adapter
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ocnt_r  <= '0;
			valid_r <= 1'b0;
		end else begin
			ocnt_r  <= negotiate_i ? ocnt_r + 4'h1 : 4'h0;
			valid_r <= negotiate_i && ocnt_r == dly_i;
		end
	end

	// Unreported fields except the contract flag show inverted data so stale values never match by luck
	assign detect_o = done_r ? {1'b1, pd_i, bc12_i, fc_i} : {1'b0, ~pd_i, ~bc12_i, ~fc_i};
	assign offer_o  = {valid_r, contract_i, valid_r ? mv_i : ~mv_i, valid_r ? ma_i : ~ma_i};
endmodule // ssp_adapter_model

// ===== sim/ssp_sink_policy_monitor.sv
module ssp_sink_policy_monitor
	import ssp_pkg::*;
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	// Inputs of the policy
	input wire ssp_detect_s detect_i,
	input wire ssp_offer_s  offer_i,
	input wire logic        renegotiating_i,
	input wire ssp_guard_s  guard_i,
	input wire logic [3:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	// Outputs of the policy
	input wire ssp_proto_e  proto_o,
	input wire logic        negotiate_o,
	input wire logic [15:0] req_min_mv_o,
	input wire logic [15:0] req_max_mv_o,
	input wire logic [15:0] req_ma_o,
	input wire logic        protocol_reset_o,
	input wire logic        fault_o,
	input wire logic        main_power_gate_enable_o,
	input wire logic        fallback_power_gate_enable_o
);
	logic [4:0] ctrl_r;
	logic       mg;
	logic       fg;
	logic       calm;

	assign mg   = main_power_gate_enable_o;
	assign fg   = fallback_power_gate_enable_o;
	assign calm = guard_i == '0 && ctrl_r == '0 && !renegotiating_i;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// Shadow of the control word, so host ownership of the gates is known
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_r <= CTRL_RESET;
		end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
			ctrl_r <= reg_wdata_i[4:0];
		end
	end

	sequence s_offer;
		negotiate_o && offer_i.valid && offer_i.contract && calm
			&& offer_i.mv >= req_min_mv_o && offer_i.mv <= req_max_mv_o;
	endsequence
	sequence s_fit; s_offer ##0 offer_i.ma >= req_ma_o; endsequence
	sequence s_short; s_offer ##0 offer_i.ma < req_ma_o; endsequence

	property p_match; s_fit |=> mg ##1 !fault_o; endproperty
	a_match: assert property (p_match) else $error("gate or fault wrong after fit");
	property p_short; s_short |=> !mg ##1 fault_o; endproperty
	a_short: assert property (p_short) else $error("no fault after short offer");
	property p_fb; s_short ##0 req_min_mv_o != VREQ0_MV |=> fg; endproperty
	a_fb: assert property (p_fb) else $error("fallback gate missing");
	property p_excl; !(mg && fg); endproperty
	a_excl: assert property (p_excl) else $error("both gates on");
	property p_ovuv; guard_i.ov || guard_i.uv |-> !mg; endproperty
	a_ovuv: assert property (p_ovuv) else $error("main gate on with bus out of range");
	property p_conn; guard_i.conn_ov |-> !fg; endproperty
	a_conn: assert property (p_conn) else $error("fallback on in connector overvoltage");
	property p_fbdis; ctrl_r[CTRL_FB_DIS] |-> !fg; endproperty
	a_fbdis: assert property (p_fbdis) else $error("fallback on while disabled");
	property p_five; req_min_mv_o == VREQ0_MV |-> !fg; endproperty
	a_five: assert property (p_five) else $error("fallback on with 5 V accepted");
	property p_host;
		ctrl_r[CTRL_HOST_EN] && !guard_i.ov && !guard_i.uv |-> mg == ctrl_r[CTRL_HOST_ON];
	endproperty
	a_host: assert property (p_host) else $error("host gate command ignored");
	property p_hold; renegotiating_i && guard_i == '0 |=> $stable(fault_o); endproperty
	a_hold: assert property (p_hold) else $error("fault moved in renegotiation");
	property p_trip;
		$rose(guard_i.oc) && (mg || fg) && !ctrl_r[CTRL_HOST_EN]
			|=> protocol_reset_o && fault_o && !mg && !fg;
	endproperty
	a_trip: assert property (p_trip) else $error("overcurrent not recovered");
	property p_pd; $rose(negotiate_o) && $past(detect_i.pd) |-> proto_o == PR_PD; endproperty
	a_pd: assert property (p_pd) else $error("PD not preferred");
endmodule // ssp_sink_policy_monitor

bind ssp_sink_policy ssp_sink_policy_monitor mon_u (.clk_i, .reset_n_i, .detect_i, .offer_i,
	.renegotiating_i, .guard_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .proto_o, .negotiate_o,
	.req_min_mv_o, .req_max_mv_o, .req_ma_o, .protocol_reset_o, .fault_o,
	.main_power_gate_enable_o, .fallback_power_gate_enable_o);

// ===== sim/ssp_sink_policy_tb.sv
module ssp_sink_policy_tb
	import ssp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [11:0] vmin, vmax, co, fi;
		logic        strap, pd, bc;
		logic [2:0]  fc;
		logic [15:0] lo, hi, ma;
		ssp_proto_e  pr;
	} ssp_row_s;

	logic        clk_i, reset_n_i, legacy_select_pullup_i, renegotiating_i, reg_wr_i, reg_rd_i;
	logic        negotiate_o, protocol_reset_o, fault_o;
	logic        main_power_gate_enable_o, fallback_power_gate_enable_o;
	logic [11:0] min_voltage_setting_i, max_voltage_setting_i;
	logic [11:0] coarse_current_setting_i, fine_current_setting_i;
	ssp_detect_s detect_i;
	ssp_offer_s  offer_i;
	ssp_guard_s  guard_i;
	ssp_proto_e  proto_o;
	logic [3:0]  reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, rv;
	logic [15:0] req_min_mv_o, req_max_mv_o, req_ma_o, mv, ma;
	logic        pd, bc, ctr;
	logic [2:0]  fc;
	logic [3:0]  dly;
	int          bad_count, checked;
	// Band edges on both sides except 787 mV, tested only at the edge; the PD row is last so later tests start from its contract
	ssp_row_s    rows [5] = '{
		'{12'h0f8, 12'h0f9, 12'h0f9, 12'h0f8, 0, 0, 1, 7, 16'h1388, 16'h2328, 16'h03e8, PR_BC12},
		'{12'hada, 12'hadb, 12'hadb, 12'h781, 0, 0, 0, 1, 16'h4a38, 16'h4e20, 16'h170c, PR_FC0},
		'{12'hadb, 12'h780, 12'h781, 12'h313, 1, 0, 0, 7, 16'h3a98, 16'h3a98, 16'h1194, PR_TYPEC},
		'{12'h000, 12'h000, 12'h000, 12'h000, 0, 0, 0, 0, 16'h1388, 16'h1388, 16'h0000, PR_TYPEC},
		'{12'h313, 12'h544, 12'h543, 12'h780, 0, 1, 1, 7, 16'h2ee0, 16'h3a98, 16'h0abe, PR_PD}};

	ssp_sink_policy dut_u (.clk_i, .reset_n_i, .min_voltage_setting_i, .max_voltage_setting_i,
		.coarse_current_setting_i, .fine_current_setting_i, .legacy_select_pullup_i, .detect_i,
		.offer_i, .renegotiating_i, .guard_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .proto_o, .negotiate_o, .req_min_mv_o, .req_max_mv_o, .req_ma_o,
		.protocol_reset_o, .fault_o, .main_power_gate_enable_o, .fallback_power_gate_enable_o);
	ssp_adapter_model adp_u (.clk_i, .reset_n_i, .negotiate_i(negotiate_o), .detect_o(detect_i),
		.offer_o(offer_i), .pd_i(pd), .bc12_i(bc), .fc_i(fc), .contract_i(ctr), .mv_i(mv),
		.ma_i(ma), .dly_i(dly));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task ck(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 rv = reg_rdata_o;
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		tick(3000);
		bad_count++;
		$display("ERROR at %0t: watchdog expired", $time);
		wrap_up;
	end

	initial begin
		{reset_n_i, legacy_select_pullup_i, renegotiating_i, reg_wr_i, reg_rd_i} = '0;
		{min_voltage_setting_i, max_voltage_setting_i} = '0;
		{coarse_current_setting_i, fine_current_setting_i} = '0;
		{guard_i, reg_addr_i, reg_wdata_i, pd, bc, fc, bad_count, checked} = '0;
		{ctr, mv, ma, dly} = {1'b1, 16'h2ee0, 16'h0bb8, 4'h1};
		foreach (rows[k]) begin
			min_voltage_setting_i    <= rows[k].vmin;
			max_voltage_setting_i    <= rows[k].vmax;
			coarse_current_setting_i <= rows[k].co;
			fine_current_setting_i   <= rows[k].fi;
			legacy_select_pullup_i   <= rows[k].strap;
			{pd, bc, fc}             <= {rows[k].pd, rows[k].bc, rows[k].fc};
			reset_n_i                <= 1'b0;
			tick(12);
			reset_n_i <= 1'b1;
			tick(3);
			#1 ck(req_min_mv_o, rows[k].lo);
			ck(req_max_mv_o, rows[k].hi);
			ck(req_ma_o, rows[k].ma);
			for (int i = 0; i < 20 && negotiate_o !== 1'b1; i++) tick(1);
			#1 ck(proto_o, rows[k].pr);
			$display("row %0d done", k);
		end
		for (int i = 0; i < 20 && main_power_gate_enable_o !== 1'b1; i++) tick(1);
		tick(2);
		#1 ck(main_power_gate_enable_o, 1'b1);
		ck(fault_o, 1'b0);
		rd(REG_STATUS);
		ck(rv[2], 1'b1);
		rd(4'h2);
		ck(rv[15:0], 16'h0000);
		$display("contract test done");
		ma              <= 16'h0100;
		renegotiating_i <= 1'b1;
		tick(1);
		renegotiating_i <= 1'b0;
		tick(1);
		#1 ck(fault_o, 1'b0);
		for (int i = 0; i < 20 && fallback_power_gate_enable_o !== 1'b1; i++) tick(1);
		tick(2);
		#1 ck(fault_o, 1'b1);
		ck(fallback_power_gate_enable_o, 1'b1);
		guard_i.conn_ov <= 1'b1;
		#1 ck(fallback_power_gate_enable_o, 1'b0);
		guard_i.conn_ov <= 1'b0;
		wr(REG_CTRL, 32'h0000_0001);
		ck(fallback_power_gate_enable_o, 1'b0);
		wr(REG_CTRL, 32'h0000_0018);
		ck(main_power_gate_enable_o, 1'b1);
		guard_i.ov <= 1'b1;
		#1 ck(main_power_gate_enable_o, 1'b0);
		tick(1);
		guard_i.ov <= 1'b0;
		wr(REG_CTRL, 32'h0000_0008);
		ck(main_power_gate_enable_o, 1'b0);
		wr(REG_CTRL, 32'h0000_0000);
		$display("gate control test done");
		for (int i = 0; i < 40 && fallback_power_gate_enable_o !== 1'b1; i++) tick(1);
		#1 guard_i.oc <= 1'b1;
		tick(1);
		#1 ck(protocol_reset_o, 1'b1);
		ck(fault_o, 1'b1);
		ck(fallback_power_gate_enable_o, 1'b0);
		{guard_i.oc, ma} <= {1'b0, 16'h0bb8};
		for (int i = 0; i < 40 && main_power_gate_enable_o !== 1'b1; i++) tick(1);
		tick(2);
		#1 ck(fault_o, 1'b0);
		$display("recovery test done");
		wr(REG_CTRL, 32'h0000_0004);
		guard_i.hot <= 1'b1;
		tick(1);
		#1 ck(fault_o, 1'b1);
		$display("thermal test done");
		wrap_up;
	end
endmodule // ssp_sink_policy_tb
